/* hw/flash_program_erase_ctrl.sv */
// Flash program/erase control interlocks with Avalon-MM register and array access.
// Summary of operation
// - First armed array write loads capture latches.
// - Later array writes ignored while armed.
// - Control registers stay accessible during operation.
// - Pulse enable refused without prior capture.
// - Arm cannot clear while pulse enabled.
// - Wipe select frozen while pulse enabled.
// - Arm, capture write, enable in order.
// - Guard blocks programming boot block words.
// - Erase includes boot block only unguarded.
// - Stop or wait aborts operation immediately.
// - Test bits reachable only in special mode.
// - Test register cleared outside special mode.
// - Special mode behaves normally until invoked.
// - Array reads depend on control bits.
// - Enable with arm clear does nothing.
// - Unarmed array ignores writes, serves reads.
`timescale 1ns/100ps
module flash_program_erase_ctrl (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Avalon-MM slave.
  input wire logic [flash_pe_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Processor mode lines.
  input wire logic special_test_line,
  input wire logic cpu_stop,
  input wire logic cpu_wait,
  // Array high voltage gate.
  output logic high_voltage_gate
);
  import flash_pe_pkg::*;

  typedef struct packed {
    seq_state_t st;
    logic arm;
    logic wipe;
    logic hv;
    logic swai;
    logic guard;
    logic captured;
    logic [7:0] test;
    logic [ARRAY_AW-1:0] lat_addr;
    logic [DATA_W-1:0] lat_data;
    logic [31:0] rdata;
    logic ack;
    logic rd_pend;
    logic aborted;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic [1:0] special_test_line_sync;
  logic [1:0] stop_sync;
  logic [1:0] wait_sync;
  logic [DATA_W-1:0] arr_rdata;
  logic prog_en;
  logic erase_en;
  logic halt;
  logic is_array;
  logic [ARRAY_AW-1:0] arr_idx;
  logic [ARRAY_AW-1:0] rd_idx;
  logic access;

  // Asynchronous mode lines pass two flip-flops.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      special_test_line_sync <= 2'h0;
      stop_sync <= 2'h0;
      wait_sync <= 2'h0;
    end else begin
      special_test_line_sync <= {special_test_line_sync[0], special_test_line};
      stop_sync <= {stop_sync[0], cpu_stop};
      wait_sync <= {wait_sync[0], cpu_wait};
    end
  end

  assign halt = stop_sync[1] || wait_sync[1];
  assign is_array = avs_address[ADDR_W-1];
  assign arr_idx = avs_address[ARRAY_AW:1];
  assign access = (avs_read || avs_write) && !s_q.ack;
  assign rd_idx = (s_q.arm && !s_q.wipe) ? s_q.lat_addr : arr_idx;
  assign prog_en = s_q.hv && !halt && !s_q.wipe &&
                   !(s_q.guard && (s_q.lat_addr >= BOOT_START));
  assign erase_en = s_q.hv && !halt && s_q.wipe;

  flash_array_mem flash_array_mem_inst (
    .clk(clk),
    .sys_rst(sys_rst),
    .rd_addr(rd_idx),
    .rd_data(arr_rdata),
    .prog_en(prog_en),
    .prog_addr(s_q.lat_addr),
    .prog_data(s_q.lat_data),
    .erase_en(erase_en),
    .erase_boot(!s_q.guard)
  );

  always_comb begin
    s_d = s_q;
    s_d.ack = 1'b0;
    s_d.aborted = 1'b0;
    if (s_q.rd_pend) begin
      s_d.rd_pend = 1'b0;
      s_d.ack = 1'b1;
      s_d.rdata = s_q.hv ? 32'h0000_0000 : {16'h0000, arr_rdata};
    end else if (access && avs_write) begin
      s_d.ack = 1'b1;
      if (is_array) begin
        if (s_q.arm && !s_q.captured) begin
          s_d.lat_addr = arr_idx;
          s_d.lat_data = avs_writedata[DATA_W-1:0];
          s_d.captured = 1'b1;
        end
      end else if (avs_address == CTRL_OFF && avs_byteenable[0]) begin
        if (s_q.hv) begin
          s_d.hv = avs_writedata[HV_BIT];
        end else begin
          s_d.arm = avs_writedata[ARM_BIT];
          s_d.wipe = avs_writedata[WIPE_BIT];
          s_d.swai = avs_writedata[SWAI_BIT];
          if (!avs_writedata[ARM_BIT]) begin
            s_d.captured = 1'b0;
          end
          s_d.hv = avs_writedata[HV_BIT] && s_q.arm && s_q.captured &&
                   avs_writedata[ARM_BIT];
        end
      end else if (avs_address == TEST_OFF && avs_byteenable[0]) begin
        // Test bits writable in special mode.
        if (special_test_line_sync[1]) begin
          s_d.test = avs_writedata[7:0] & TEST_MASK;
        end
      end else if (avs_address == GUARD_OFF && avs_byteenable[0]) begin
        if (!s_q.hv) begin
          s_d.guard = avs_writedata[0];
        end
      end
    end else if (access && avs_read) begin
      if (is_array) begin
        s_d.rd_pend = 1'b1;
      end else begin
        s_d.ack = 1'b1;
        if (avs_address == CTRL_OFF) begin
          s_d.rdata = 32'h0000_0000;
          s_d.rdata[HV_BIT] = s_q.hv;
          s_d.rdata[ARM_BIT] = s_q.arm;
          s_d.rdata[WIPE_BIT] = s_q.wipe;
          s_d.rdata[SWAI_BIT] = s_q.swai;
        end else if (avs_address == TEST_OFF) begin
          s_d.rdata = {24'h000000, s_q.test};
        end else if (avs_address == GUARD_OFF) begin
          s_d.rdata = {31'h0, s_q.guard};
        end else if (avs_address == STAT_OFF) begin
          s_d.rdata = {28'h0000000, halt, s_q.captured, s_q.st};
        end else begin
          s_d.rdata = 32'h0000_0000;
        end
      end
    end
    // Stop or wait aborts the pulse.
    if (halt && s_d.hv) begin
      s_d.hv = 1'b0;
      s_d.aborted = s_q.hv;
    end
    // Test register cleared outside special mode.
    if (!special_test_line_sync[1]) begin
      s_d.test = TEST_RST;
    end
    if (s_d.hv) begin
      s_d.st = ST_HV;
    end else if (s_d.captured) begin
      s_d.st = ST_CAPTURED;
    end else if (s_d.arm) begin
      s_d.st = ST_ARMED;
    end else begin
      s_d.st = ST_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
      s_q.arm <= CTRL_RST[ARM_BIT];
      s_q.wipe <= CTRL_RST[WIPE_BIT];
      s_q.hv <= CTRL_RST[HV_BIT];
      s_q.guard <= GUARD_RST;
      s_q.test <= TEST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_readdata = s_q.rdata;
  assign avs_waitrequest = (avs_read || avs_write) && !s_q.ack;
  // Gate follows enable outside stop or wait.
  assign high_voltage_gate = s_q.hv && !halt;

  // Assertions.
  // Enable needs prior capture.
  a_capture_needed: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(s_q.hv) |-> $past(s_q.captured) && $past(s_q.arm))
    else $error("pulse enable rose without capture");

  a_arm_held: assert property (@(posedge clk) disable iff (sys_rst)
    s_q.hv && s_d.hv |-> s_d.arm && (s_d.wipe == s_q.wipe))
    else $error("arm or wipe changed under pulse enable");

  a_wipe_frozen: assert property (@(posedge clk) disable iff (sys_rst)
    s_q.hv |=> s_q.wipe == $past(s_q.wipe))
    else $error("wipe select changed while enabled");

  a_latch_stable: assert property (@(posedge clk) disable iff (sys_rst)
    s_q.captured && s_q.arm |=> $stable(s_q.lat_addr) || !$past(s_q.arm))
    else $error("latched address changed while armed");

  a_halt_abort: assert property (@(posedge clk) disable iff (sys_rst)
    halt |-> !high_voltage_gate ##1 !s_q.hv)
    else $error("high voltage not aborted on stop");

  a_test_clear: assert property (@(posedge clk) disable iff (sys_rst)
    !special_test_line_sync[1] |=> s_q.test == TEST_RST)
    else $error("test register not cleared");

  a_boot_guard: assert property (@(posedge clk) disable iff (sys_rst)
    prog_en |-> !(s_q.guard && s_q.lat_addr >= BOOT_START))
    else $error("boot block programmed under guard");

  a_unarmed_capture: assert property (@(posedge clk) disable iff (sys_rst)
    !s_q.arm |=> !s_q.captured || $past(s_q.captured))
    else $error("capture without arm");

  a_bus_answer: assert property (@(posedge clk) disable iff (sys_rst)
    avs_write && !is_array |-> ##[0:1] !avs_waitrequest)
    else $error("register write not answered");

  a_reg_read_answer: assert property (@(posedge clk) disable iff (sys_rst)
    avs_read && !is_array |-> ##[0:1] !avs_waitrequest)
    else $error("register read not answered");

  a_enable_refused: assert property (@(posedge clk) disable iff (sys_rst)
    !s_q.hv && !s_q.captured |=> !s_q.hv)
    else $error("pulse enable set without capture");

  a_first_capture: assert property (@(posedge clk) disable iff (sys_rst)
    access && avs_write && is_array && s_q.arm && !s_q.captured && !s_q.rd_pend |=>
    s_q.captured && (s_q.lat_addr == $past(arr_idx)) &&
    (s_q.lat_data == $past(avs_writedata[DATA_W-1:0])))
    else $error("first armed write not latched");

  a_unarmed_idle: assert property (@(posedge clk) disable iff (sys_rst)
    !s_q.arm |-> !prog_en && !erase_en)
    else $error("array altered while unarmed");

  a_read_ignored: assert property (@(posedge clk) disable iff (sys_rst)
    s_q.rd_pend && s_q.hv |=> avs_readdata == 32'h0000_0000)
    else $error("array read answered under pulse enable");

  a_guard_frozen: assert property (@(posedge clk) disable iff (sys_rst)
    s_q.hv |=> s_q.guard == $past(s_q.guard))
    else $error("boot guard changed while enabled");

  // Main scenarios reached.
  c_guard_block: cover property (@(posedge clk) disable iff (sys_rst)
    s_q.hv && !s_q.wipe && s_q.guard && (s_q.lat_addr >= BOOT_START));
  c_program: cover property (@(posedge clk) disable iff (sys_rst) prog_en);
  c_erase: cover property (@(posedge clk) disable iff (sys_rst) erase_en);
  c_abort: cover property (@(posedge clk) disable iff (sys_rst) s_q.aborted);
  c_refuse: cover property (@(posedge clk) disable iff (sys_rst)
    avs_write && avs_address == CTRL_OFF && avs_writedata[HV_BIT] && !s_q.captured);
endmodule : flash_program_erase_ctrl

/* pkg/flash_pe_pkg.sv */
// Package with register map, field positions and reset values of the flash program/erase control.
package flash_pe_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int ARRAY_AW = 14;
  // Register byte addresses on the Avalon-MM slave.
  localparam logic [ADDR_W-1:0] CTRL_OFF = 16'h0000;
  localparam logic [ADDR_W-1:0] TEST_OFF = 16'h0004;
  localparam logic [ADDR_W-1:0] GUARD_OFF = 16'h0008;
  localparam logic [ADDR_W-1:0] STAT_OFF = 16'h000c;
  localparam logic [ADDR_W-1:0] ARRAY_BASE = 16'h8000;
  // Boot block covers the top of the array: array word index at or above this.
  localparam logic [ARRAY_AW-1:0] BOOT_START = 14'h3c00;
  // Control register field positions.
  localparam int HV_BIT = 0;
  localparam int ARM_BIT = 1;
  localparam int WIPE_BIT = 2;
  localparam int SWAI_BIT = 4;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] TEST_RST = 8'h00;
  localparam logic [7:0] TEST_MASK = 8'hff;
  localparam logic GUARD_RST = 1'b1;
  localparam logic [DATA_W-1:0] ERASED_WORD = 16'hffff;
  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_CAPTURED, ST_HV} seq_state_t;
endpackage : flash_pe_pkg

/* hw/flash_array_mem.sv */
// Flash array storage model with program (AND) and bulk erase operations.
`timescale 1ns/100ps
module flash_array_mem (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Read port.
  input wire logic [flash_pe_pkg::ARRAY_AW-1:0] rd_addr,
  output logic [flash_pe_pkg::DATA_W-1:0] rd_data,
  // Program and erase strobes.
  input wire logic prog_en,
  input wire logic [flash_pe_pkg::ARRAY_AW-1:0] prog_addr,
  input wire logic [flash_pe_pkg::DATA_W-1:0] prog_data,
  input wire logic erase_en,
  input wire logic erase_boot
);
  import flash_pe_pkg::*;
  localparam int DEPTH = 1 << ARRAY_AW;
  logic [DATA_W-1:0] mem [DEPTH];
  // Programming can only clear bits; erase returns cells to ones.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_addr];
    end
    if (erase_en) begin
      for (int i = 0; i < DEPTH; i++) begin
        if (erase_boot || (i[ARRAY_AW-1:0] < BOOT_START)) begin
          mem[i] <= ERASED_WORD;
        end
      end
    end else if (prog_en) begin
      mem[prog_addr] <= mem[prog_addr] & prog_data;
    end
  end
endmodule : flash_array_mem

/* testbench/cpu_bus_master.sv */
// CPU-side bus master model that runs the flash programming software.
`timescale 1ns/100ps
module cpu_bus_master (
  // Clock.
  input wire logic clk,
  // Avalon-MM master side.
  output logic [flash_pe_pkg::ADDR_W-1:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  // Set when a transfer does not complete within 50 cycles.
  output logic hang
);
  import flash_pe_pkg::*;
  assign avs_byteenable = 4'hf;
  initial begin
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    hang = 1'b0;
  end
  // Holds the request until waitrequest is sampled low or 50 cycles pass.
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) hang <= 1'b1;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : xfer
  task automatic pulse_op(input logic [7:0] c, input logic [13:0] wd, input logic [15:0] d);
    xfer(1'b1, CTRL_OFF, {24'h0, c});
    xfer(1'b1, ARRAY_BASE | {1'b0, wd, 1'b0}, {16'h0, d});
    xfer(1'b1, CTRL_OFF, {24'h0, c | 8'h01});
    repeat (3) @(posedge clk);
    xfer(1'b1, CTRL_OFF, {24'h0, c});
    xfer(1'b1, CTRL_OFF, 32'h0);
  endtask : pulse_op
endmodule : cpu_bus_master

/* testbench/testbench.sv */
// Self-checking testbench of the flash program/erase control.
`timescale 1ns/100ps
module testbench;
  import flash_pe_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic special_test_line = 1'b0;
  logic cpu_stop = 1'b0;
  logic cpu_wait = 1'b0;
  logic [15:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic high_voltage_gate;
  logic hang;
  logic [15:0] d;
  int err_count = 0;
  int n_checks = 0;
  logic [31:0] exp_q[$];
  always #50 clk = ~clk;
  cpu_bus_master cpu_bus_master_inst (.clk(clk), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest), .hang(hang));
  flash_program_erase_ctrl flash_program_erase_ctrl_inst (.clk(clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .special_test_line(special_test_line), .cpu_stop(cpu_stop), .cpu_wait(cpu_wait),
    .high_voltage_gate(high_voltage_gate));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  task automatic compare_val(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : compare_val
  task automatic chk_gate(input logic e);
    repeat (2) @(negedge clk);
    compare_val({31'h0, high_voltage_gate}, {31'h0, e});
  endtask : chk_gate
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    cpu_bus_master_inst.xfer(1'b0, a, 32'h0);
  endtask : rd
  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    cpu_bus_master_inst.xfer(1'b1, a, v);
  endtask : wr
  function automatic logic [15:0] aw(input logic [13:0] wd);
    return ARRAY_BASE | {1'b0, wd, 1'b0};
  endfunction : aw
  always @(posedge clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) compare_val(avs_readdata, exp_q.pop_front());
  end
  always @(posedge hang) begin
    err_count++;
    complete_run();
  end
  initial begin
    void'($urandom(32'hf5e295fe));
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    rd(CTRL_OFF, {24'h0, CTRL_RST});
    rd(GUARD_OFF, {31'h0, GUARD_RST});
    rd(TEST_OFF, {24'h0, TEST_RST});
    rd(16'h0010, 32'h0);
    $display("reset test done");
    wr(GUARD_OFF, 32'h0);
    cpu_bus_master_inst.pulse_op(8'h06, 14'h0, 16'h0);
    rd(aw(BOOT_START), {16'h0, ERASED_WORD});
    cpu_bus_master_inst.pulse_op(8'h02, BOOT_START, 16'h00ff);
    wr(GUARD_OFF, 32'h1);
    cpu_bus_master_inst.pulse_op(8'h06, 14'h0, 16'h0);
    rd(aw(BOOT_START), 32'h00ff);
    cpu_bus_master_inst.pulse_op(8'h02, BOOT_START, 16'h0000);
    rd(aw(BOOT_START), 32'h00ff);
    wr(aw(1), 32'h0);
    rd(aw(1), {16'h0, ERASED_WORD});
    $display("erase test done");
    wr(CTRL_OFF, 32'h1);
    rd(CTRL_OFF, 32'h0);
    chk_gate(1'b0);
    wr(CTRL_OFF, 32'h2);
    wr(CTRL_OFF, 32'h3);
    rd(CTRL_OFF, 32'h2);
    d = 16'($urandom) & 16'h7ffe;
    wr(aw(5), {16'h0, d});
    wr(aw(6), {16'h0, ~d});
    rd(STAT_OFF, {28'h0, 1'b0, 1'b1, ST_CAPTURED});
    wr(CTRL_OFF, 32'h3);
    rd(CTRL_OFF, 32'h3);
    wr(CTRL_OFF, 32'h1);
    rd(CTRL_OFF, 32'h3);
    wr(CTRL_OFF, 32'h7);
    rd(CTRL_OFF, 32'h3);
    rd(aw(5), 32'h0);
    chk_gate(1'b1);
    wr(CTRL_OFF, 32'h2);
    rd(aw(9), {16'h0, d});
    wr(CTRL_OFF, 32'h0);
    rd(aw(6), {16'h0, ERASED_WORD});
    rd(aw(5), {16'h0, d});
    $display("program test done");
    for (int k = 0; k < 2; k++) begin
      wr(CTRL_OFF, 32'h2);
      wr(aw(20), 32'h0);
      wr(CTRL_OFF, 32'h3);
      chk_gate(1'b1);
      @(posedge clk);
      if (k == 0) cpu_stop <= 1'b1;
      else cpu_wait <= 1'b1;
      repeat (5) @(posedge clk);
      chk_gate(1'b0);
      rd(CTRL_OFF, 32'h2);
      rd(STAT_OFF, {28'h0, 1'b1, 1'b1, ST_CAPTURED});
      @(posedge clk);
      cpu_stop <= 1'b0;
      cpu_wait <= 1'b0;
      wr(CTRL_OFF, 32'h0);
    end
    $display("abort test done");
    wr(TEST_OFF, 32'ha5);
    rd(TEST_OFF, 32'h0);
    special_test_line <= 1'b1;
    repeat (4) @(posedge clk);
    wr(TEST_OFF, 32'ha5);
    rd(TEST_OFF, 32'ha5);
    wr(CTRL_OFF, 32'h10);
    rd(CTRL_OFF, 32'h10);
    wr(CTRL_OFF, 32'h0);
    rd(CTRL_OFF, 32'h0);
    special_test_line <= 1'b0;
    repeat (4) @(posedge clk);
    rd(TEST_OFF, 32'h0);
    $display("test mode test done");
    repeat (3) @(posedge clk);
    compare_val(32'(exp_q.size()), 32'h0);
    complete_run();
  end
endmodule : testbench
